// [tsense_pkg.sv]
package tsense_pkg;
	localparam logic [3:0] DEV_ADDR_HI = 4'h3;
	localparam int unsigned CLK_HZ = 40000000;
	localparam int unsigned CONV_HZ = 8;
	localparam int unsigned CONV_CYCLES = CLK_HZ / CONV_HZ;
	localparam int unsigned NUM_REGS = 16;
	localparam logic [3:0] REG_CAP = 4'h0;
	localparam logic [3:0] REG_CFG = 4'h1;
	localparam logic [3:0] REG_TEMP = 4'h5;
	localparam logic [3:0] REG_MFR = 4'h6;
	localparam logic [3:0] REG_DEV = 4'h7;
	localparam logic [3:0] REG_LAST_USED = 4'h7;
	localparam logic [15:0] CAP_RESET = 16'h0017;
	localparam logic [15:0] ZERO_RESET = 16'h0000;
	localparam int unsigned CFG_EVENT_EN_BIT = 3;
	localparam int unsigned CFG_EVENT_POL_BIT = 1;
	localparam int unsigned BYTE_MSB = 7;
	localparam logic [3:0] ACK_BIT = 4'h8;
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	typedef enum {ST_IDLE, ST_ADDR, ST_CMD, ST_WHI, ST_WLO, ST_RHI, ST_RLO, ST_IGNORE} state_t;
endpackage : tsense_pkg

// [tsense_slave.sv]
`timescale 1ns/100ps
`default_nettype none
module tsense_slave #(
	parameter int unsigned CONV_CYCLES = tsense_pkg::CONV_CYCLES,
	parameter logic [15:0] MFR_ID = 16'h00a5, // arbitrary identity value
	parameter logic [15:0] DEV_ID = 16'h0100 // arbitrary identity value
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic SCL,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	input wire logic ADDR_SELECT_BIT0,
	input wire logic ADDR_SELECT_BIT1,
	input wire logic ADDR_SELECT_BIT2,
	input wire logic [15:0] TEMP_SAMPLE,
	input wire logic ALARM_REQ,
	output logic ALARM_OUT,
	output logic ALARM_OE
);
	// ==========================================
	// input sampling
	logic [2:0] scl_s_q;
	logic [2:0] sda_s_q;
	logic scl_q;
	logic sda_q;
	always_ff @(posedge CLK) begin
		if (RST) begin
			scl_s_q <= 3'h7;
			sda_s_q <= 3'h7;
		end else begin
			scl_s_q <= {scl_s_q[1:0], SCL};
			sda_s_q <= {sda_s_q[1:0], SDA_IN};
		end
	end
	// a level counts once stages two and three agree, which also eats short spikes
	always_ff @(posedge CLK) begin
		if (RST) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			if (scl_s_q[1] == scl_s_q[2]) scl_q <= scl_s_q[2];
			if (sda_s_q[1] == sda_s_q[2]) sda_q <= sda_s_q[2];
		end
	end
	logic scl_d1_q;
	logic sda_d1_q;
	always_ff @(posedge CLK) begin
		if (RST) begin
			scl_d1_q <= 1'b1;
			sda_d1_q <= 1'b1;
		end else begin
			scl_d1_q <= scl_q;
			sda_d1_q <= sda_q;
		end
	end
	// straps are pins too, so they pass the same three-stage sampler as the bus lines
	logic [2:0] strap1_q;
	logic [2:0] strap2_q;
	logic [2:0] strap3_q;
	logic [2:0] strap_q;
	always_ff @(posedge CLK) begin
		if (RST) begin
			strap1_q <= '0;
			strap2_q <= '0;
			strap3_q <= '0;
			strap_q <= '0;
		end else begin
			strap1_q <= {ADDR_SELECT_BIT2, ADDR_SELECT_BIT1, ADDR_SELECT_BIT0};
			strap2_q <= strap1_q;
			strap3_q <= strap2_q;
			if (strap2_q == strap3_q) strap_q <= strap3_q;
		end
	end
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	assign scl_rise = scl_q & ~scl_d1_q;
	assign scl_fall = ~scl_q & scl_d1_q;
	assign start_ev = scl_q & scl_d1_q & sda_d1_q & ~sda_q;
	assign stop_ev = scl_q & scl_d1_q & ~sda_d1_q & sda_q;

	// ==========================================
	// conversion tick and register file
	logic [31:0] conv_cnt_q;
	logic conv_tick;
	assign conv_tick = (conv_cnt_q == CONV_CYCLES - 1);
	always_ff @(posedge CLK) begin
		if (RST) conv_cnt_q <= '0;
		else if (conv_tick) conv_cnt_q <= '0;
		else conv_cnt_q <= conv_cnt_q + 32'd1;
	end
	logic [15:0] regs_q [tsense_pkg::NUM_REGS];
	logic [3:0] ptr_q;
	logic [15:0] wdata_q;
	logic wr_commit;
	// commit one cycle late so that both bytes of wdata_q have landed
	logic commit_q;
	always_ff @(posedge CLK) begin
		if (RST) commit_q <= 1'b0;
		else commit_q <= wr_commit;
	end
	always_ff @(posedge CLK) begin
		if (RST) begin
			for (int i = 0; i < tsense_pkg::NUM_REGS; i++) regs_q[i] <= tsense_pkg::ZERO_RESET;
			regs_q[tsense_pkg::REG_CAP] <= tsense_pkg::CAP_RESET;
		end else begin
			if (conv_tick) regs_q[tsense_pkg::REG_TEMP] <= TEMP_SAMPLE;
			// only configuration and thresholds take writes; id and temperature are read only
			if (commit_q && ptr_q >= tsense_pkg::REG_CFG && ptr_q < tsense_pkg::REG_TEMP) regs_q[ptr_q] <= wdata_q;
		end
	end
	function automatic logic [15:0] read_reg(input logic [3:0] idx);
		if (idx == tsense_pkg::REG_MFR) read_reg = MFR_ID;
		else if (idx == tsense_pkg::REG_DEV) read_reg = DEV_ID;
		else if (idx > tsense_pkg::REG_LAST_USED) read_reg = tsense_pkg::ZERO_RESET;
		else read_reg = regs_q[idx];
	endfunction : read_reg
	logic [15:0] rd_word;
	assign rd_word = read_reg(ptr_q);

	// ==========================================
	// serial engine
	tsense_pkg::state_t state_q;
	logic [3:0] bit_q;
	logic [7:0] shift_q;
	logic [7:0] tx_q;
	logic [7:0] tx_lo_q;
	logic sda_low_q;
	logic lead_fall_q;
	logic [6:0] own_addr;
	assign own_addr = {tsense_pkg::DEV_ADDR_HI, strap_q};
	logic sending;
	assign sending = (state_q == tsense_pkg::ST_RHI) || (state_q == tsense_pkg::ST_RLO);
	assign wr_commit = (state_q == tsense_pkg::ST_WLO) && scl_fall && bit_q == tsense_pkg::ACK_BIT;

	always_ff @(posedge CLK) begin
		if (RST) begin
			state_q <= tsense_pkg::ST_IDLE;
			bit_q <= '0;
			shift_q <= '0;
			tx_q <= '0;
			tx_lo_q <= '0;
			ptr_q <= '0;
			wdata_q <= '0;
			sda_low_q <= 1'b0;
			lead_fall_q <= 1'b0;
		end else if (start_ev) begin
			state_q <= tsense_pkg::ST_ADDR;
			bit_q <= '0;
			sda_low_q <= 1'b0;
			lead_fall_q <= 1'b1;
		end else if (stop_ev) begin
			state_q <= tsense_pkg::ST_IDLE;
			sda_low_q <= 1'b0;
			lead_fall_q <= 1'b0;
		end else if (scl_rise && bit_q <= tsense_pkg::LAST_DATA_BIT && !sending) begin
			shift_q <= {shift_q[6:0], sda_q};
		end else if (scl_rise && bit_q == tsense_pkg::ACK_BIT && sending && sda_q) begin
			state_q <= tsense_pkg::ST_IGNORE;
		end else if (scl_fall && lead_fall_q) begin
			// the clock fall that closes a start carries no bit, so it must not count
			lead_fall_q <= 1'b0;
		end else if (scl_fall && state_q != tsense_pkg::ST_IDLE && state_q != tsense_pkg::ST_IGNORE) begin
			// all changes to data happen just after clock falls
			sda_low_q <= 1'b0;
			if (bit_q == tsense_pkg::LAST_DATA_BIT) begin
				bit_q <= tsense_pkg::ACK_BIT;
				if (!sending) begin
					case (state_q)
						tsense_pkg::ST_ADDR: begin
							if (shift_q[7:1] == own_addr) sda_low_q <= 1'b1;
							else state_q <= tsense_pkg::ST_IGNORE;
						end
						default: sda_low_q <= 1'b1;
					endcase
				end
			end else if (bit_q == tsense_pkg::ACK_BIT) begin
				bit_q <= '0;
				case (state_q)
					tsense_pkg::ST_ADDR: begin
						if (shift_q[0]) begin
							state_q <= tsense_pkg::ST_RHI;
							tx_q <= rd_word[15:8];
							tx_lo_q <= rd_word[7:0];
							sda_low_q <= ~rd_word[15];
						end else state_q <= tsense_pkg::ST_CMD;
					end
					tsense_pkg::ST_CMD: begin
						ptr_q <= shift_q[3:0];
						state_q <= tsense_pkg::ST_WHI;
					end
					tsense_pkg::ST_WHI: begin
						wdata_q[15:8] <= shift_q;
						state_q <= tsense_pkg::ST_WLO;
					end
					tsense_pkg::ST_WLO: begin
						wdata_q[7:0] <= shift_q;
						state_q <= tsense_pkg::ST_IGNORE;
					end
					tsense_pkg::ST_RHI: begin
						state_q <= tsense_pkg::ST_RLO;
						tx_q <= tx_lo_q;
						sda_low_q <= ~tx_lo_q[tsense_pkg::BYTE_MSB];
					end
					default: state_q <= tsense_pkg::ST_IGNORE;
				endcase
			end else begin
				bit_q <= bit_q + 4'h1;
				if (sending) begin
					tx_q <= {tx_q[6:0], 1'b0};
					sda_low_q <= ~tx_q[6];
				end
			end
		end
	end
	// ==========================================
	// pins
	assign SDA_OUT = 1'b0;
	assign SDA_OE = sda_low_q;
	assign ALARM_OUT = 1'b0;
	assign ALARM_OE = ALARM_REQ & regs_q[tsense_pkg::REG_CFG][tsense_pkg::CFG_EVENT_EN_BIT];

	// ==========================================
	// checks
	a_sda_only_low: assert property (@(posedge CLK) disable iff (RST)
		SDA_OE |-> SDA_OUT == 1'b0) else $error("data pin driven high");
	a_alarm_only_low: assert property (@(posedge CLK) disable iff (RST)
		ALARM_OE |-> ALARM_OUT == 1'b0) else $error("alarm pin driven high");
	a_sda_stable_high: assert property (@(posedge CLK) disable iff (RST)
		(scl_q && scl_d1_q && !start_ev && !stop_ev) |=> $stable(SDA_OE) || $fell(scl_q)) else $error("data moved in clock high");
	a_start_resets: assert property (@(posedge CLK) disable iff (RST)
		start_ev |=> state_q == tsense_pkg::ST_ADDR && bit_q == 4'h0 && !SDA_OE) else $error("start did not restart");
	a_stop_idles: assert property (@(posedge CLK) disable iff (RST)
		stop_ev && !start_ev |=> state_q == tsense_pkg::ST_IDLE && !SDA_OE) else $error("stop did not idle");
	a_addr_match_ack: assert property (@(posedge CLK) disable iff (RST)
		(state_q == tsense_pkg::ST_ADDR && scl_fall && bit_q == tsense_pkg::LAST_DATA_BIT && !start_ev && !stop_ev
		&& shift_q[7:1] == own_addr) |=> SDA_OE && bit_q == tsense_pkg::ACK_BIT) else $error("own address not acked");
	a_addr_miss_quiet: assert property (@(posedge CLK) disable iff (RST)
		(state_q == tsense_pkg::ST_ADDR && scl_fall && bit_q == tsense_pkg::LAST_DATA_BIT && !start_ev && !stop_ev
		&& shift_q[7:1] != own_addr) |=> !SDA_OE && state_q == tsense_pkg::ST_IGNORE) else $error("foreign address acked");
	a_ignore_silent: assert property (@(posedge CLK) disable iff (RST)
		state_q == tsense_pkg::ST_IGNORE |-> !SDA_OE) else $error("drove data while ignoring");
	a_temp_refresh: assert property (@(posedge CLK) disable iff (RST)
		conv_tick |=> regs_q[tsense_pkg::REG_TEMP] == $past(TEMP_SAMPLE)) else $error("temperature not refreshed");
	a_cmd_pointer: assert property (@(posedge CLK) disable iff (RST)
		(state_q == tsense_pkg::ST_CMD && scl_fall && bit_q == tsense_pkg::ACK_BIT && !start_ev && !stop_ev)
		|=> ptr_q == $past(shift_q[3:0]) && state_q == tsense_pkg::ST_WHI) else $error("pointer not loaded");
	c_word_read: cover property (@(posedge CLK) state_q == tsense_pkg::ST_RLO ##1 state_q == tsense_pkg::ST_IGNORE);
	c_word_write: cover property (@(posedge CLK) wr_commit);
	c_addr_miss: cover property (@(posedge CLK) state_q == tsense_pkg::ST_ADDR ##1 state_q == tsense_pkg::ST_IGNORE);
	c_repeat_start: cover property (@(posedge CLK) state_q == tsense_pkg::ST_WHI && start_ev);
endmodule : tsense_slave
`default_nettype wire

// [smbus_host.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========
// bus master model; clock and data rest released while idle
module smbus_host (
	input wire logic clk,
	input wire logic sda_wire,
	output logic scl,
	output logic sda_drv,
	output logic res_stb,
	output logic [7:0] res_val
);
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
		res_stb = 1'b0;
		res_val = 8'h00;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	// data moves mid-low so the 3-flop sampler never sees it race the clock
	task automatic bit_io(input logic b, output logic r);
		scl <= 1'b0;
		tick(3);
		sda_drv <= b;
		tick(3);
		scl <= 1'b1;
		tick(2);
		r = sda_wire;
	endtask : bit_io
	// the low phase must outlast the sensor's release of its ack, or a false stop is seen
	task automatic start();
		scl <= 1'b0;
		tick(3);
		sda_drv <= 1'b1;
		tick(4);
		scl <= 1'b1;
		tick(4);
		sda_drv <= 1'b0;
		tick(4);
	endtask : start
	task automatic stop();
		scl <= 1'b0;
		tick(3);
		sda_drv <= 1'b0;
		tick(4);
		scl <= 1'b1;
		tick(4);
		sda_drv <= 1'b1;
		tick(4);
	endtask : stop
	task automatic report(input logic [7:0] v);
		res_val <= v;
		res_stb <= 1'b1;
		tick(1);
		res_stb <= 1'b0;
	endtask : report
	task automatic byte_out(input logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(b[i], r);
		bit_io(1'b1, r);
		report({7'h00, r});
	endtask : byte_out
	task automatic byte_in(input logic nack);
		logic [7:0] d;
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(nack, r);
		report(d);
	endtask : byte_in
endmodule : smbus_host
`default_nettype wire

// [temp_sensor_word_register_slave_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module temp_sensor_word_register_slave_tb;
	typedef struct packed {logic is_ack; logic [7:0] val;} note_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic scl, sda_drv, sda_wire, sda_out, sda_oe, res_stb, alarm_req, alarm_out, alarm_oe;
	logic [7:0] res_val;
	logic [2:0] sel;
	logic [15:0] temp, d;
	logic [31:0] v;
	logic [6:0] a;
	int seed, n_errors = 0, n_compared = 0;
	note_t q[$];
	note_t n;
	always #12.5 clk = ~clk;
	// open drain with pull-up: low wins
	assign sda_wire = (sda_oe ? sda_out : 1'b1) & sda_drv;
	tsense_slave #(.CONV_CYCLES(100)) tsense_slave_i (.CLK(clk), .RST(rst), .SCL(scl), .SDA_IN(sda_wire),
		.SDA_OUT(sda_out), .SDA_OE(sda_oe), .ADDR_SELECT_BIT0(sel[0]), .ADDR_SELECT_BIT1(sel[1]),
		.ADDR_SELECT_BIT2(sel[2]), .TEMP_SAMPLE(temp), .ALARM_REQ(alarm_req), .ALARM_OUT(alarm_out),
		.ALARM_OE(alarm_oe));
	smbus_host smbus_host_i (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv),
		.res_stb(res_stb), .res_val(res_val));
	// ==========
	// checking
	task automatic cmp_bit(input logic e, input logic g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("FAIL t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : cmp_bit
	task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("FAIL t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : cmp_byte
	always @(posedge clk) begin
		if (res_stb === 1'b1 && q.size() == 0) begin
			n_errors++;
			$display("FAIL t=%0t exp=%h got=%h", $time, 8'h00, res_val);
		end else if (res_stb === 1'b1) begin
			n = q.pop_front();
			if (n.is_ack) cmp_bit(n.val[0], res_val[0]);
			else cmp_byte(n.val, res_val);
		end
	end
	task automatic print_verdict();
		$display("errors=%0d compared=%0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : print_verdict
	// ==========
	// transfers
	task automatic send(input logic [7:0] b, input logic ack);
		q.push_back({1'b1, 7'h00, ack});
		smbus_host_i.byte_out(b);
	endtask : send
	task automatic read_word(input logic [7:0] cmd, input logic [15:0] e);
		smbus_host_i.start();
		send({a, 1'b0}, 1'b0);
		send(cmd, 1'b0);
		smbus_host_i.start();
		send({a, 1'b1}, 1'b0);
		q.push_back({1'b0, e[15:8]});
		smbus_host_i.byte_in(1'b0);
		q.push_back({1'b0, e[7:0]});
		smbus_host_i.byte_in(1'b1);
		smbus_host_i.stop();
	endtask : read_word
	task automatic write_word(input logic [7:0] cmd, input logic [15:0] w);
		smbus_host_i.start();
		send({a, 1'b0}, 1'b0);
		send(cmd, 1'b0);
		send(w[15:8], 1'b0);
		send(w[7:0], 1'b0);
		smbus_host_i.stop();
	endtask : write_word
	initial begin
		repeat (100000) @(posedge clk);
		n_errors++;
		print_verdict();
	end
	initial begin
		seed = 27;
		sel = 3'h0;
		temp = 16'h0000;
		alarm_req = 1'b0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		cmp_bit(1'b0, sda_oe);
		for (int i = 0; i < 8; i++) begin
			sel <= i[2:0];
			a = {tsense_pkg::DEV_ADDR_HI, i[2:0]};
			@(posedge clk);
			read_word(8'h00, tsense_pkg::CAP_RESET);
		end
		v = $random(seed);
		temp <= v[15:0];
		alarm_req <= 1'b1;
		repeat (250) @(posedge clk);
		// command high nibble is random deliberately: only the low nibble selects
		read_word({v[31:28], tsense_pkg::REG_TEMP}, v[15:0]);
		cmp_bit(1'b0, alarm_oe);
		d = v[15:0] | 16'h0008;
		write_word({4'h0, tsense_pkg::REG_CFG}, d);
		read_word({4'h0, tsense_pkg::REG_CFG}, d);
		cmp_bit(1'b1, alarm_oe);
		cmp_bit(1'b0, alarm_out);
		write_word(8'h00, v[31:16]);
		read_word(8'h00, tsense_pkg::CAP_RESET);
		smbus_host_i.start();
		send({4'h4, sel, 1'b0}, 1'b1);
		send(8'h05, 1'b1);
		smbus_host_i.stop();
		read_word({4'h0, tsense_pkg::REG_TEMP}, v[15:0]);
		for (int i = 0; i < 100 && q.size() != 0; i++) @(posedge clk);
		if (q.size() != 0) n_errors++;
		print_verdict();
	end
endmodule : temp_sensor_word_register_slave_tb
`default_nettype wire
